// ==== hw/local_bus_command_controller.v ====
// Local bus cycle sequencer: watches the processor status lines and
// drives address latch, cascade, transceiver and command strobes.
// Assumes one system clock; every pin input is asynchronous and is
// synchronised, so each sample is two clocks behind the pin.
// Functional notes
// - Status state is followed by command states
// - Ready high repeats command state, outputs hold
// - Ready low ends cycle, status may restart
// - Back-to-back cycles keep isolated output timing, except an unshared write after a read: transceiver enable one clock late
// - Unshared consecutive writes keep transceiver lines high
// - Shared mode delays read commands one clock
// - Shared mode delays write commands two clocks
// - Shared mode delays write transceiver enable one clock
// - Shared mode drops transceiver enable between cycles
// - Address strobe in status second half only
// - Cascade enable one clock longer on acknowledge
// - Bus select latched; low keeps commands, direction and command-state enable inactive
// - Unselected cycle ignores delay, enable and ready
// - Unselected unshared write still raises early transceiver enable for the status clock
// - Grant loss floats commands, drops transceiver enable
// - Grant fall: enable at once, commands three edges later
// - Unshared command enable gates outputs immediately
// - Ready still ends cycle while enable low
// - Command only after delay input sampled low
// - Delay input never touches control outputs
// - Halt cycles drive no command or control output
// - Each bus state lasts two clocks
// - Status lines sampled every clock, either starts
// - Direction high unless reading, changes with enable low
// - Delay sampled at status end and every later clock
`include "bus_ctrl_map.vh"
`timescale 1ns/1ps
module local_bus_command_controller (
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite register port
    input wire [7:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output wire [1:0] bresp,
    output wire bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    output wire arready,
    output wire [31:0] rdata,
    output wire [1:0] rresp,
    output wire rvalid,
    input wire rready,
    // Processor status, active low
    input wire status_line_hi,
    input wire status_line_lo,
    // High for a memory cycle, low for I/O
    input wire mem_io_sel,
    // Cycle end, active low
    input wire ready_n,
    // High postpones the command
    input wire command_delay_in,
    // Latched bus select
    input wire bus_select_latched_in,
    // Enable, or grant (active low) in shared mode
    input wire command_enable_in,
    // Control outputs
    output reg addr_latch_en,
    output reg cascade_enable_out,
    output wire transceiver_enable,
    output reg transceiver_direction,
    // Command pins with their output enables
    output wire io_read_cmd_n,
    output wire io_read_cmd_oe,
    output wire io_write_cmd_n,
    output wire io_write_cmd_oe,
    output wire mem_read_cmd_n,
    output wire mem_read_cmd_oe,
    output wire mem_write_cmd_n,
    output wire mem_write_cmd_oe,
    output wire irq_ack_cmd_n,
    output wire irq_ack_cmd_oe
);
    // Bus states; one clock each except command (two phases)
    localparam ST_IDLE = 3'h0;
    localparam ST_TS = 3'h1;
    localparam ST_TC1 = 3'h2;
    localparam ST_TC2 = 3'h3;
    localparam ST_UNSEL = 3'h4;
    localparam ST_HALT = 3'h5;

    // Cycle types from the status decode
    localparam TYPE_RD = 2'h0;
    localparam TYPE_WR = 2'h1;
    localparam TYPE_ACK = 2'h2;
    localparam TYPE_HALT = 2'h3;

    wire [31:0] ctrl; // Control register
    wire shared; // Shared bus mode select
    wire [6:0] pins_s; // Synchronised pin levels
    wire hi_s;
    wire lo_s;
    wire mio_s;
    wire ready_n_s;
    wire dly_s;
    wire bsel_s;
    wire en_s;
    wire arbiter_grant_n; // Grant view of the enable pin
    wire status_active;
    reg [1:0] dec_type;

    reg [2:0] state;
    reg [2:0] next_state;
    reg [1:0] cyc_type; // Type of the current cycle
    reg [1:0] next_type;
    reg cyc_mem; // Memory (1) or I/O (0)
    reg next_mem;
    reg sel; // Bus select caught at status end
    reg next_sel;
    reg cmd_ok; // Delay input has been seen low
    reg next_ok;
    reg [1:0] age; // Clocks spent in command states
    reg [1:0] next_age;
    reg cmd_on; // Command level before gating
    reg xcvr_en; // Transceiver enable before gating
    reg [1:0] grant_cnt; // Edges since grant fell
    reg [31:0] cycle_count; // Completed selected cycles

    wire next_in_tc;
    wire next_is_wr;
    wire next_is_rd;
    wire [1:0] cmd_delay;
    wire next_cmd;
    wire next_xcvr;
    wire next_dir;
    wire end_cycle;
    wire cmd_gate;
    wire xcvr_gate;
    wire cmd_act;
    wire pins_oe;
    wire [31:0] stat_word;

    // Register slave; control bit steers the timing mode
    reg_slave u_regs (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .ctrl(ctrl),
        .stat_in(stat_word),
        .count_in(cycle_count)
    );

    assign shared = ctrl[`CTRL_SHARED_BIT];

    // All pins are asynchronous to aclk
    sync2 #(
        .WIDTH(7),
        .RESET_VAL(`PIN_IDLE)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({status_line_hi, status_line_lo, mem_io_sel, ready_n,
              command_delay_in, bus_select_latched_in, command_enable_in}),
        .dout(pins_s)
    );

    assign hi_s = pins_s[6];
    assign lo_s = pins_s[5];
    assign mio_s = pins_s[4];
    assign ready_n_s = pins_s[3];
    assign dly_s = pins_s[2];
    assign bsel_s = pins_s[1];
    assign en_s = pins_s[0];
    assign arbiter_grant_n = en_s;

    // Either status line low starts a cycle
    assign status_active = ~hi_s | ~lo_s;

    // Status decode into cycle type
    always @* begin
        case ({hi_s, lo_s})
            2'b00: dec_type = mio_s ? TYPE_HALT : TYPE_ACK;
            2'b01: dec_type = TYPE_RD;
            2'b10: dec_type = TYPE_WR;
            default: dec_type = TYPE_RD;
        endcase
    end

    // Sequencer next state; the sampling clock is the detect cycle
    always @* begin
        next_state = state;
        next_type = cyc_type;
        next_mem = cyc_mem;
        next_sel = sel;
        next_ok = cmd_ok;
        next_age = age;
        case (state)
            ST_IDLE, ST_UNSEL: begin
                // Unselected cycles wait only for new status
                if (status_active) begin
                    next_type = dec_type;
                    next_mem = mio_s;
                    if (dec_type == TYPE_HALT) begin
                        next_state = ST_HALT;
                    end else begin
                        next_state = ST_TS;
                    end
                end
            end
            ST_HALT: begin
                // Status still low here; do not retrigger
                next_state = ST_IDLE;
            end
            ST_TS: begin
                next_sel = bsel_s;
                next_ok = ~dly_s;
                next_age = 2'h0;
                if (bsel_s) begin
                    next_state = ST_TC1;
                end else begin
                    next_state = ST_UNSEL;
                end
            end
            ST_TC1: begin
                next_state = ST_TC2;
                next_ok = cmd_ok | ~dly_s;
                if (age != `AGE_MAX) begin
                    next_age = age + 2'h1;
                end
            end
            ST_TC2: begin
                next_ok = cmd_ok | ~dly_s;
                if (age != `AGE_MAX) begin
                    next_age = age + 2'h1;
                end
                // Ready counts even while commands are gated off
                if (ready_n_s) begin
                    next_state = ST_TC1;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    assign next_in_tc = (next_state == ST_TC1) || (next_state == ST_TC2);
    assign next_is_wr = (next_type == TYPE_WR);
    assign next_is_rd = (next_type == TYPE_RD) || (next_type == TYPE_ACK);
    assign end_cycle = (state == ST_TC2) && (next_state == ST_IDLE);

    // Shared mode pushes the command fall later
    assign cmd_delay = !shared ? 2'h0 :
                       (next_is_wr ? `WR_CMD_DELAY : `RD_CMD_DELAY);

    // Command waits for the delay input and its mode delay
    assign next_cmd = next_in_tc && next_sel && next_ok &&
                      (next_age >= cmd_delay);

    // Transceiver enable; delay input is never consulted here
    // Early write enable only when direction is already high,
    // so direction never moves under an active enable
    assign next_xcvr =
        (next_is_wr && !shared && (next_state == ST_TS) &&
         transceiver_direction) ||
        (next_is_wr && next_in_tc && next_sel) ||
        (next_is_wr && !shared && end_cycle && sel) ||
        (next_is_rd && next_in_tc && next_sel && (state != ST_TS));

    // Direction low for reads; a read holds it one clock past
    // the end so the enable falls first
    assign next_dir = ~((next_is_rd && next_in_tc && next_sel) ||
                        (next_is_rd && end_cycle && sel));

    // Registered outputs and sequencer state
    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            cyc_type <= TYPE_RD;
            cyc_mem <= 1'b0;
            sel <= 1'b0;
            cmd_ok <= 1'b0;
            age <= 2'h0;
            addr_latch_en <= 1'b0;
            cascade_enable_out <= 1'b0;
            xcvr_en <= 1'b0;
            transceiver_direction <= 1'b1;
            cmd_on <= 1'b0;
        end else begin
            state <= next_state;
            cyc_type <= next_type;
            cyc_mem <= next_mem;
            sel <= next_sel;
            cmd_ok <= next_ok;
            age <= next_age;
            // Strobe over the second status clock, no input gates it
            addr_latch_en <= (next_state == ST_TS);
            // Cascade enable spans the strobe plus one clock
            cascade_enable_out <= (next_type == TYPE_ACK) &&
                                  ((next_state == ST_TS) ||
                                   (state == ST_TS));
            xcvr_en <= next_xcvr;
            transceiver_direction <= next_dir;
            cmd_on <= next_cmd;
        end
    end

    // Grant edge counter; restarts whenever grant is lost
    always @(posedge aclk) begin
        if (!aresetn) begin
            grant_cnt <= 2'h0;
        end else if (arbiter_grant_n) begin
            grant_cnt <= 2'h0;
        end else if (grant_cnt != `GRANT_EDGES) begin
            grant_cnt <= grant_cnt + 2'h1;
        end
    end

    // Completed selected cycles, visible to software
    always @(posedge aclk) begin
        if (!aresetn) begin
            cycle_count <= 32'h0000_0000;
        end else if (end_cycle) begin
            cycle_count <= cycle_count + 32'h0000_0001;
        end
    end

    // Enable and grant gate outputs without waiting for a clock;
    // the arbiter is trusted to keep grant through command states
    assign cmd_gate = shared ? (grant_cnt == `GRANT_EDGES) : en_s;
    assign xcvr_gate = shared ? ~arbiter_grant_n : en_s;
    assign transceiver_enable = xcvr_en & xcvr_gate;
    assign cmd_act = cmd_on & cmd_gate;
    // Commands float only in shared mode without grant
    assign pins_oe = shared ? ~arbiter_grant_n : 1'b1;

    // One command per cycle type
    assign io_read_cmd_n = ~(cmd_act && cyc_type == TYPE_RD && !cyc_mem);
    assign mem_read_cmd_n = ~(cmd_act && cyc_type == TYPE_RD && cyc_mem);
    assign io_write_cmd_n = ~(cmd_act && cyc_type == TYPE_WR && !cyc_mem);
    assign mem_write_cmd_n = ~(cmd_act && cyc_type == TYPE_WR && cyc_mem);
    assign irq_ack_cmd_n = ~(cmd_act && cyc_type == TYPE_ACK);
    assign io_read_cmd_oe = pins_oe;
    assign io_write_cmd_oe = pins_oe;
    assign mem_read_cmd_oe = pins_oe;
    assign mem_write_cmd_oe = pins_oe;
    assign irq_ack_cmd_oe = pins_oe;

    // Status word for software
    assign stat_word = {21'h000000, shared, ~arbiter_grant_n, sel,
                        1'b0, 1'b0, cyc_type, 1'b0, state};
endmodule

// ==== hw/bus_ctrl_map.vh ====
// Constants for the local bus command controller: register offsets,
// field positions, reset values and command timing counts.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef BUS_CTRL_MAP_VH
`define BUS_CTRL_MAP_VH

// Register byte offsets on the AXI4-Lite slave
`define CTRL_ADDR 8'h00
`define STAT_ADDR 8'h04
`define COUNT_ADDR 8'h08

// Control register: shared bus mode select field
`define CTRL_SHARED_BIT 0
`define CTRL_RESET 32'h0000_0000

// Status register field positions
`define STAT_STATE_LSB 0
`define STAT_TYPE_LSB 4
`define STAT_SEL_BIT 8
`define STAT_GRANT_BIT 9
`define STAT_SHARED_BIT 10

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Command delays in shared mode, in clock cycles
`define RD_CMD_DELAY 2'h1
`define WR_CMD_DELAY 2'h2
// Clock edges from grant fall to commands allowed
`define GRANT_EDGES 2'h3
// Saturation value of the command state age counter
`define AGE_MAX 2'h3
// Synchroniser reset levels: status, ready and enable idle high
`define PIN_IDLE 7'h69

`endif

// ==== hw/sync2.v ====
// Two-flip-flop synchroniser for a group of independent pin levels.
// Assumes each bit is a slow level; bits are not kept coherent.
`timescale 1ns/1ps
module sync2 #(
    parameter WIDTH = 1,
    // Reset level of both stages, the idle level of the pins
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input wire aclk,
    input wire aresetn,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);
    // First stage, read only by the second stage
    reg [WIDTH-1:0] meta;

    // Both stages load RESET_VAL under reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// ==== hw/reg_slave.v ====
// AXI4-Lite slave holding the control register and reading back
// the controller status and completed cycle count.
// Assumes a single-clock master keeping the AXI valid/ready rules.
`include "bus_ctrl_map.vh"
`timescale 1ns/1ps
module reg_slave (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    output wire arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    output reg [31:0] ctrl,
    input wire [31:0] stat_in,
    input wire [31:0] count_in
);
    reg aw_full; // Address held until data arrives
    reg w_full; // Data held until address arrives
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    integer i;

    // Each side takes one item and waits for its partner
    assign awready = ~aw_full;
    assign wready = ~w_full;
    // One read in flight; next address waits for the answer
    assign arready = ~rvalid;

    // Write path: either order, response after both
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            ctrl <= `CTRL_RESET;
        end else begin
            if (awvalid && !aw_full) begin
                aw_full <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && !w_full) begin
                w_full <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            // Commit once both halves are held and no response pends
            if (aw_full && w_full && !bvalid) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                bvalid <= 1'b1;
                if (aw_addr == `CTRL_ADDR) begin
                    bresp <= `RESP_OKAY;
                    for (i = 0; i < 4; i = i + 1) begin
                        if (w_strb[i]) begin
                            ctrl[i*8 +: 8] <= w_data[i*8 +: 8];
                        end
                    end
                end else if (aw_addr == `STAT_ADDR || aw_addr == `COUNT_ADDR) begin
                    // Read-only registers ignore the write
                    bresp <= `RESP_OKAY;
                end else begin
                    bresp <= `RESP_SLVERR;
                end
            end
        end
    end

    // Read path: data registered one cycle after the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else if (arvalid && !rvalid) begin
            rvalid <= 1'b1;
            rresp <= `RESP_OKAY;
            case (araddr)
                `CTRL_ADDR: rdata <= ctrl;
                `STAT_ADDR: rdata <= stat_in;
                `COUNT_ADDR: rdata <= count_in;
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule

// ==== sim/bus_ctrl_chk.sv ====
// Checker for the controller's bus-side output relations.
// Assumes binding onto the controller top; sees only its pins.
`timescale 1ns/1ps
module bus_ctrl_chk (
    input wire aclk,
    input wire aresetn,
    input wire addr_latch_en,
    input wire cascade_enable_out,
    input wire transceiver_enable,
    input wire transceiver_direction,
    input wire io_read_cmd_n,
    input wire io_read_cmd_oe,
    input wire io_write_cmd_n,
    input wire io_write_cmd_oe,
    input wire mem_read_cmd_n,
    input wire mem_read_cmd_oe,
    input wire mem_write_cmd_n,
    input wire mem_write_cmd_oe,
    input wire irq_ack_cmd_n,
    input wire irq_ack_cmd_oe
);
    // Driven-low strobes only; a floated pin counts as idle
    wire [4:0] act = {~irq_ack_cmd_n & irq_ack_cmd_oe, ~mem_read_cmd_n & mem_read_cmd_oe,
        ~mem_write_cmd_n & mem_write_cmd_oe, ~io_read_cmd_n & io_read_cmd_oe, ~io_write_cmd_n & io_write_cmd_oe};
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ale_pulse_a:
    assert property ($rose(addr_latch_en) |=> !addr_latch_en) else $error("latch strobe too long");
    cascade_span_a:
    assert property ($rose(cascade_enable_out) |-> addr_latch_en ##1 (cascade_enable_out && !addr_latch_en)
        ##1 !cascade_enable_out) else $error("cascade span wrong");
    cmd_onehot_a:
    assert property ($onehot0(act)) else $error("two commands at once");
    write_dir_a:
    assert property ((act[2] | act[0]) |-> transceiver_direction) else $error("write with receive direction");
    read_dir_a:
    assert property ((act[4] | act[3] | act[1]) |-> !transceiver_direction) else $error("read with send direction");
    dir_steady_a:
    assert property ($changed(transceiver_direction) |-> !transceiver_enable && !$past(transceiver_enable))
        else $error("direction moved with enable high");
    float_quiet_a:
    assert property (!io_read_cmd_oe |-> !transceiver_enable && !mem_write_cmd_oe && !irq_ack_cmd_oe)
        else $error("floated commands with enable");
    cmd_after_status_a:
    assert property (|act |-> !addr_latch_en) else $error("command during status state");
endmodule

// ==== sim/bus_master_model.sv ====
// Processor model: status for one two-clock status state, ready
// raised at cycle start and dropped after a chosen count of clocks.
// Assumes go is a one-clock pulse given only while no cycle runs.
`timescale 1ns/1ps
module bus_master_model (
    input wire aclk,
    input wire go,
    input wire [1:0] kind,
    input wire [7:0] waits,
    output logic status_line_hi = 1'b1,
    output logic status_line_lo = 1'b1,
    output logic ready_n = 1'b0
);
    int cnt = 0; // Clocks since cycle start
    // Status and ready sequencing
    always @(posedge aclk) begin
        if (go) begin
            {status_line_hi, status_line_lo} <= kind;
            ready_n <= 1'b1;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
            // Release after two clocks, the length of a status state
            if (cnt == 1)
                {status_line_hi, status_line_lo} <= 2'h3;
            if (cnt + 1 == waits)
                ready_n <= 1'b0;
        end
    end
endmodule

// ==== sim/local_bus_command_controller_tb.sv ====
// Bench: register access and timed bus cycles in both modes.
// Assumes the processor model drives status and ready pins.
`timescale 1ns/1ps
module local_bus_command_controller_tb;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, d;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] r, kind = 2'h3;
    logic [7:0] waits = 8'h0e;
    logic go = 0, mem_io_sel = 0, command_delay_in = 0, bus_select_latched_in = 1, command_enable_in = 1;
    wire awready, wready, bvalid, arready, rvalid, status_line_hi, status_line_lo, ready_n;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire addr_latch_en, cascade_enable_out, transceiver_enable, transceiver_direction;
    wire io_read_cmd_n, io_read_cmd_oe, io_write_cmd_n, io_write_cmd_oe, mem_read_cmd_n, mem_read_cmd_oe;
    wire mem_write_cmd_n, mem_write_cmd_oe, irq_ack_cmd_n, irq_ack_cmd_oe;
    // Driven-low strobes, same bit order as the checker
    wire [4:0] act = {~irq_ack_cmd_n & irq_ack_cmd_oe, ~mem_read_cmd_n & mem_read_cmd_oe,
        ~mem_write_cmd_n & mem_write_cmd_oe, ~io_read_cmd_n & io_read_cmd_oe, ~io_write_cmd_n & io_write_cmd_oe};
    int n_fail = 0, checks_done = 0, ta, tc, te, nc, nd;
    logic [4:0] which;
    // Cycle table: read mem, read io, write mem, write io, ack
    logic [1:0] ks [5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
    logic ms [5] = '{1, 0, 1, 0, 0};
    int wb [5] = '{3, 1, 2, 0, 4};
    int c1 [5] = '{2, 2, 3, 3, 2};
    int e0 [5] = '{2, 2, 0, 0, 2};
    int e1 [5] = '{2, 2, 1, 1, 2};
    local_bus_command_controller dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .status_line_hi, .status_line_lo, .mem_io_sel, .ready_n, .command_delay_in, .bus_select_latched_in,
        .command_enable_in, .addr_latch_en, .cascade_enable_out, .transceiver_enable, .transceiver_direction,
        .io_read_cmd_n, .io_read_cmd_oe, .io_write_cmd_n, .io_write_cmd_oe, .mem_read_cmd_n, .mem_read_cmd_oe,
        .mem_write_cmd_n, .mem_write_cmd_oe, .irq_ack_cmd_n, .irq_ack_cmd_oe);
    bus_master_model cpu_u (.aclk, .go, .kind, .waits, .status_line_hi, .status_line_lo, .ready_n);
    // 200 MHz clock
    initial begin
        forever #2.5 aclk = ~aclk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Ready values are read mid-cycle, where they are settled
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
        logic tka = 0, tkw = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(tka && tkw)) begin
            @(negedge aclk);
            tka |= awready;
            tkw |= wready;
            @(posedge aclk);
            if (tka) awvalid <= 0;
            if (tkw) wvalid <= 0;
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        @(posedge aclk);
        bready <= 0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic tk = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        while (!tk) begin
            @(negedge aclk);
            tk = arready;
            @(posedge aclk);
            if (tk) arvalid <= 0;
        end
        do @(negedge aclk); while (rvalid !== 1'b1);
        v = rdata;
        rs = rresp;
        @(posedge aclk);
        rready <= 0;
    endtask
    // One cycle over 40 clocks; at clock hold either grant or delay falls
    task automatic run_cycle(input logic [1:0] k, input logic m, input int hold, input bit g);
        kind <= k;
        mem_io_sel <= m;
        go <= 1;
        @(posedge aclk);
        go <= 0;
        {ta, tc, te, nc, nd, which} = {-32'sd1, -32'sd1, -32'sd1, 69'h0};
        for (int t = 0; t < 40; t++) begin
            @(negedge aclk);
            if (addr_latch_en && ta < 0) ta = t;
            if (|act && tc < 0) tc = t;
            if (transceiver_enable && te < 0) te = t;
            which |= act;
            nc += cascade_enable_out;
            nd += !transceiver_direction;
            @(posedge aclk);
            if (t == hold && g) command_enable_in <= 0;
            else if (t == hold) command_delay_in <= 0;
        end
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog well beyond the fewer than a thousand clocks the tests need
    initial begin
        #40us;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        axi_read(8'h00, d, r);
        check(d, 32'h0);
        axi_read(8'h0c, d, r);
        check(r, 32'h2);
        for (int md = 0; md < 2; md++) begin
            command_enable_in <= (md == 0);
            axi_write(8'h00, md);
            axi_read(8'h00, d, r);
            check(d, md);
            for (int i = 0; i < 5; i++) begin
                run_cycle(ks[i], ms[i], 99, 0);
                check(which, 5'h1 << wb[i]);
                check(tc - ta, md ? c1[i] : 1);
                check(te - ta, md ? e1[i] : e0[i]);
                check(nc, i == 4 ? 2 : 0);
            end
            if (md == 0) begin
                command_delay_in <= 1;
                run_cycle(2'h1, 1, 6, 0);
                check(which, 5'h08);
                check(tc >= 8, 1);
                check(te - ta, 2);
                run_cycle(2'h0, 1, 99, 0);
                check(ta, -1);
                check(which, 0);
                bus_select_latched_in <= 0;
                waits <= 8'h02;
                run_cycle(2'h2, 1, 99, 0);
                check(which, 0);
                check(nd, 0);
                bus_select_latched_in <= 1;
                waits <= 8'h0e;
            end else begin
                command_enable_in <= 1;
                repeat (4) @(posedge aclk);
                @(negedge aclk);
                check({io_read_cmd_oe, transceiver_enable}, 2'h0);
                @(posedge aclk);
                run_cycle(2'h1, 1, 4, 1);
                check(which, 5'h08);
                check(tc >= 8, 1);
            end
        end
        axi_read(8'h08, d, r);
        check(d, 32'h0000_000c);
        tally_and_finish();
    end
endmodule
bind local_bus_command_controller bus_ctrl_chk chk_u (.aclk, .aresetn, .addr_latch_en, .cascade_enable_out,
    .transceiver_enable, .transceiver_direction, .io_read_cmd_n, .io_read_cmd_oe, .io_write_cmd_n,
    .io_write_cmd_oe, .mem_read_cmd_n, .mem_read_cmd_oe, .mem_write_cmd_n, .mem_write_cmd_oe,
    .irq_ack_cmd_n, .irq_ack_cmd_oe);
